// *** design/ccm_cfg.svh ***
// constants for the console manual-control block
// Functional notes
// - system reset loads micro address zero into the micro address register.
// - system reset acts whether the clock runs or is stopped.
// - reset clears registers with good parity, general and float registers kept.
// - reset clears latches except machine-reset and diagnostic; diagnostic forces priority.
// - reset sets machine-reset latch, which inhibits all micro traps.
// - start after reset loops diagnostic 128 times unless check-compare disabled.
// - after diagnostic, clear control-word flag bytes, then clear machine-reset latch.
// - override key sets latch gating switch digits into micro address, blocking next-address.
// - override accepted only with clock stopped; load happens at next start.
// - override after reset clears machine-reset and diagnostic; start skips both routines.
// - start after normal stop restarts clock, status unchanged.
// - second start after reset loads status word from address zero.
// - counter-set only when stopped; on release start clock, trap to 0001.
// - after counter-set trap stop at 0FF once channel share cycles finish.
// - counter-set after reset clears control-word flags before loading counter.
// - check reset clears check register and check latches, clock running or not.
// - stop finishes instruction, takes pending interrupts, then stops; manual lamp lit.
// - stop waits for I/O including chaining to complete.
// - stopped state still serves share traps, selector cycles, shows next address.
// - timer switch off holds timer latch set, blocking counter drive pulses.
// - each indicator ORs lamp test with its functional input.
// - selector decodes three-position inner and sixteen-position outer controls.
`ifndef CCM_CFG_SVH
`define CCM_CFG_SVH
`define CCM_ADDR_RESET 16'h0000
`define CCM_ADDR_SET_IC 16'h0001
`define CCM_ADDR_IC_STOP 16'h00FF
`define CCM_ADDR_LOAD_PSW 16'h0000
`define CCM_DIAG_LOOPS 8'h80
`define CCM_KEY_COUNT 7
`define CCM_LAMP_COUNT 8
`define CCM_KEY_SYS_RESET 0
`define CCM_KEY_OVERRIDE 1
`define CCM_KEY_START 2
`define CCM_KEY_SET_IC 3
`define CCM_KEY_CHK_RESET 4
`define CCM_KEY_STOP 5
`define CCM_KEY_LOAD 6
`define CCM_INNER_1 2'h1
`define CCM_INNER_2 2'h2
`define CCM_INNER_3 2'h3
`define CCM_OUTER_MS 4'h0
`define CCM_OUTER_AS 4'h1
`endif

// *** design/ccm_pkg.sv ***
// types for the console manual-control block
package ccm_pkg;
    typedef enum logic [2:0] {
        CCM_STOPPED = 3'h0,
        CCM_DIAG = 3'h1,
        CCM_CLEAR_FLAGS = 3'h2,
        CCM_RUN = 3'h3,
        CCM_SET_IC = 3'h4,
        CCM_STOPPING = 3'h5
    } ccm_state_type;
    typedef enum logic [1:0] {
        CCM_SEL_REG = 2'h0,
        CCM_SEL_MAIN = 2'h1,
        CCM_SEL_AUX = 2'h2,
        CCM_SEL_NONE = 2'h3
    } ccm_sel_type;
endpackage : ccm_pkg

// *** design/ccm_key_sync.sv ***
// key synchroniser and press edge detector
`timescale 1ns/100ps
module ccm_key_sync (
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    input wire logic key_i,
    output logic press_o,
    output logic release_o
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // first stage feeds only the second
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= key_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign press_o = sync_q & ~last_q;
    assign release_o = ~sync_q & last_q;
endmodule : ccm_key_sync

// *** design/ccm_console_ctrl.sv ***
// console manual-control logic: keys, clock gating, resets, selector, lamps
`timescale 1ns/100ps
`include "ccm_cfg.svh"
module ccm_console_ctrl
    import ccm_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    input wire logic [`CCM_KEY_COUNT-1:0] KEYS_I,
    input wire logic [15:0] DATA_SW_I,
    input wire logic [1:0] SEL_INNER_I,
    input wire logic [3:0] SEL_OUTER_I,
    input wire logic CHECK_COMPARE_DISABLE_I,
    input wire logic TIMER_SWITCH_ON_I,
    input wire logic LAMP_TEST_I,
    input wire logic [`CCM_LAMP_COUNT-1:0] LAMP_FUNC_I,
    input wire logic [15:0] NEXT_MICRO_ADDR_I,
    input wire logic DIAG_PASS_DONE_I,
    input wire logic FLAGS_CLEAR_DONE_I,
    input wire logic INSTR_END_I,
    input wire logic INTR_PENDING_I,
    input wire logic IO_BUSY_I,
    input wire logic SHARE_PENDING_I,
    input wire logic SHARE_REQ_I,
    input wire logic SEL_DATA_REQ_I,
    input wire logic TRAP_REQ_I,
    output logic [15:0] MICRO_ADDR_O,
    output logic CPU_CLOCK_RUN_O,
    output logic SYS_RESET_O,
    output logic REG_CLEAR_O,
    output logic MACHINE_RESET_LATCH_O,
    output logic DIAG_LATCH_O,
    output logic PRIORITY_LATCH_O,
    output logic OVERRIDE_LATCH_O,
    output logic TRAP_ENABLE_O,
    output logic DIAG_RUN_O,
    output logic CLEAR_FLAGS_O,
    output logic LOAD_PSW_O,
    output logic LOAD_INSTR_COUNTER_O,
    output logic [15:0] INSTR_COUNTER_DATA_O,
    output logic CHECK_RESET_O,
    output logic MANUAL_LAMP_O,
    output logic SHARE_SERVE_O,
    output logic SEL_CYCLE_SERVE_O,
    output logic SHOW_NEXT_ADDR_O,
    output logic TIMER_CTRL_LATCH_O,
    output logic [`CCM_LAMP_COUNT-1:0] LAMP_DRIVE_O,
    output logic [1:0] SEL_KIND_O,
    output logic [3:0] SEL_REG_INNER_O,
    output logic [3:0] SEL_REG_OUTER_O
);
    logic [`CCM_KEY_COUNT-1:0] press;
    logic [`CCM_KEY_COUNT-1:0] release_ev;
    ccm_state_type state_q;
    logic mreset_q;
    logic diag_q;
    logic prio_q;
    logic override_q;
    logic after_reset_q;
    logic second_start_q;
    logic ic_pending_q;
    logic stop_req_q;
    logic [7:0] diag_cnt_q;
    logic [15:0] addr_q;
    logic [15:0] ic_data_q;
    logic load_psw_q;
    logic load_ic_q;
    logic chk_reset_q;
    logic sys_reset_q;
    logic clock_stopped;
    logic sys_reset_ev;
    ccm_sel_type sel_kind_d;
    ccm_sel_type sel_kind_q;
    logic [3:0] sel_inner_d;
    logic [3:0] sel_inner_q;
    logic [3:0] sel_outer_d;
    logic [3:0] sel_outer_q;

    genvar gk;
    generate
        for (gk = 0; gk < `CCM_KEY_COUNT; gk++) begin : g_key
            ccm_key_sync u_sync (
                .CLK_SYS_I(CLK_SYS_I),
                .RESET_I(RESET_I),
                .key_i(KEYS_I[gk]),
                .press_o(press[gk]),
                .release_o(release_ev[gk])
            );
        end
    endgenerate

    assign clock_stopped = (state_q == CCM_STOPPED);
    // load key press also performs a system reset
    assign sys_reset_ev = press[`CCM_KEY_SYS_RESET] | press[`CCM_KEY_LOAD];

    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            sys_reset_q <= 1'b1;
        end else begin
            sys_reset_q <= sys_reset_ev;
        end
    end

    // machine-reset, diagnostic and priority latches
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            mreset_q <= 1'b1;
            diag_q <= 1'b1;
            prio_q <= 1'b1;
        end else if (sys_reset_ev) begin
            mreset_q <= 1'b1;
            diag_q <= 1'b1;
            prio_q <= 1'b1;
        end else if (press[`CCM_KEY_OVERRIDE] && clock_stopped && after_reset_q) begin
            mreset_q <= 1'b0;
            diag_q <= 1'b0;
        end else if (state_q == CCM_CLEAR_FLAGS && FLAGS_CLEAR_DONE_I) begin
            mreset_q <= 1'b0;
            diag_q <= 1'b0;
        end
    end

    // override latch, honoured only while stopped
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I || sys_reset_ev) begin
            override_q <= 1'b0;
        end else if (press[`CCM_KEY_OVERRIDE] && clock_stopped) begin
            override_q <= 1'b1;
        end else if (!clock_stopped) begin
            override_q <= 1'b0;
        end
    end

    // remembers reset state for the start and counter-set sequences
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I || sys_reset_ev) begin
            after_reset_q <= 1'b1;
            second_start_q <= 1'b0;
        end else begin
            if (press[`CCM_KEY_OVERRIDE] && clock_stopped) begin
                after_reset_q <= 1'b0;
            end else if (state_q == CCM_CLEAR_FLAGS && FLAGS_CLEAR_DONE_I) begin
                after_reset_q <= 1'b0;
                // a counter-set boot resumes at the counter, not the status word
                second_start_q <= !ic_pending_q;
            end else if (state_q == CCM_RUN) begin
                second_start_q <= 1'b0;
            end
        end
    end

    // stop request waits for the instruction end
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I || sys_reset_ev || clock_stopped) begin
            stop_req_q <= 1'b0;
        end else if (press[`CCM_KEY_STOP]) begin
            stop_req_q <= 1'b1;
        end
    end

    // diagnostic pass counter, idle at zero outside the loop
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I || sys_reset_ev || state_q != CCM_DIAG) begin
            diag_cnt_q <= 8'h00;
        end else if (DIAG_PASS_DONE_I) begin
            diag_cnt_q <= diag_cnt_q + 8'h01;
        end
    end

    // counter-set in progress, kept across the flag clear
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I || sys_reset_ev) begin
            ic_pending_q <= 1'b0;
        end else if (clock_stopped && release_ev[`CCM_KEY_SET_IC]) begin
            ic_pending_q <= 1'b1;
        end else if (state_q == CCM_SET_IC && !SHARE_PENDING_I
                && addr_q == `CCM_ADDR_IC_STOP) begin
            ic_pending_q <= 1'b0;
        end
    end

    // main sequencer
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I || sys_reset_ev) begin
            state_q <= CCM_STOPPED;
        end else begin
            unique case (state_q)
                CCM_STOPPED: begin
                    if (release_ev[`CCM_KEY_SET_IC]) begin
                        state_q <= after_reset_q ? CCM_CLEAR_FLAGS : CCM_SET_IC;
                    end else if (press[`CCM_KEY_START] || release_ev[`CCM_KEY_LOAD]) begin
                        if (after_reset_q && diag_q && !CHECK_COMPARE_DISABLE_I) begin
                            state_q <= CCM_DIAG;
                        end else if (after_reset_q && diag_q) begin
                            state_q <= CCM_CLEAR_FLAGS;
                        end else begin
                            state_q <= CCM_RUN;
                        end
                    end
                end
                CCM_DIAG: begin
                    if (DIAG_PASS_DONE_I) begin
                        if (diag_cnt_q == `CCM_DIAG_LOOPS - 8'h01) begin
                            state_q <= CCM_CLEAR_FLAGS;
                        end
                    end
                end
                CCM_CLEAR_FLAGS: begin
                    if (FLAGS_CLEAR_DONE_I) begin
                        // start after reset ends stopped; counter-set goes on
                        state_q <= ic_pending_q ? CCM_SET_IC : CCM_STOPPED;
                    end
                end
                CCM_SET_IC: begin
                    // hold until share cycles drain before stopping
                    if (!SHARE_PENDING_I && addr_q == `CCM_ADDR_IC_STOP) begin
                        state_q <= CCM_STOPPED;
                    end
                end
                CCM_RUN: begin
                    if (stop_req_q && INSTR_END_I) begin
                        state_q <= CCM_STOPPING;
                    end
                end
                CCM_STOPPING: begin
                    if (!INTR_PENDING_I && !IO_BUSY_I) begin
                        state_q <= CCM_STOPPED;
                    end
                end
                default: begin
                    state_q <= CCM_STOPPED;
                end
            endcase
        end
    end

    // micro address register
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I || sys_reset_ev) begin
            addr_q <= `CCM_ADDR_RESET;
        end else if (clock_stopped && release_ev[`CCM_KEY_SET_IC]
                && !after_reset_q) begin
            addr_q <= `CCM_ADDR_SET_IC;
        end else if (state_q == CCM_CLEAR_FLAGS && FLAGS_CLEAR_DONE_I && ic_pending_q) begin
            addr_q <= `CCM_ADDR_SET_IC;
        end else if (clock_stopped && override_q && press[`CCM_KEY_START]) begin
            addr_q <= DATA_SW_I;
        end else if (clock_stopped && second_start_q && press[`CCM_KEY_START]) begin
            addr_q <= `CCM_ADDR_LOAD_PSW;
        end else if (!clock_stopped && !(state_q == CCM_SET_IC
                && addr_q == `CCM_ADDR_IC_STOP)) begin
            addr_q <= NEXT_MICRO_ADDR_I;
        end
    end

    // one-cycle action pulses and latched counter data
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            load_psw_q <= 1'b0;
            load_ic_q <= 1'b0;
            ic_data_q <= 16'h0000;
            chk_reset_q <= 1'b0;
        end else begin
            load_psw_q <= clock_stopped && second_start_q && press[`CCM_KEY_START]
                && !override_q;
            chk_reset_q <= press[`CCM_KEY_CHK_RESET] | sys_reset_ev;
            load_ic_q <= (state_q == CCM_SET_IC) && (addr_q == `CCM_ADDR_SET_IC);
            if (clock_stopped && press[`CCM_KEY_SET_IC]) begin
                ic_data_q <= DATA_SW_I;
            end
        end
    end

    assign MICRO_ADDR_O = addr_q;
    assign CPU_CLOCK_RUN_O = ~clock_stopped;
    assign SYS_RESET_O = sys_reset_q;
    assign REG_CLEAR_O = sys_reset_q;
    assign MACHINE_RESET_LATCH_O = mreset_q;
    assign DIAG_LATCH_O = diag_q;
    assign PRIORITY_LATCH_O = prio_q;
    assign OVERRIDE_LATCH_O = override_q;
    assign TRAP_ENABLE_O = TRAP_REQ_I & ~mreset_q & ~override_q;
    assign DIAG_RUN_O = (state_q == CCM_DIAG);
    assign CLEAR_FLAGS_O = (state_q == CCM_CLEAR_FLAGS);
    assign LOAD_PSW_O = load_psw_q;
    assign LOAD_INSTR_COUNTER_O = load_ic_q;
    assign INSTR_COUNTER_DATA_O = ic_data_q;
    assign CHECK_RESET_O = chk_reset_q;
    assign MANUAL_LAMP_O = clock_stopped | LAMP_TEST_I;
    // share traps bypass the clock gate
    assign SHARE_SERVE_O = SHARE_REQ_I;
    assign SEL_CYCLE_SERVE_O = SEL_DATA_REQ_I;
    assign SHOW_NEXT_ADDR_O = clock_stopped;
    assign TIMER_CTRL_LATCH_O = ~TIMER_SWITCH_ON_I;

    genvar gl;
    generate
        for (gl = 0; gl < `CCM_LAMP_COUNT; gl++) begin : g_lamp
            assign LAMP_DRIVE_O[gl] = LAMP_FUNC_I[gl] | LAMP_TEST_I;
        end
    endgenerate

    // selector decode
    always_comb begin
        sel_kind_d = CCM_SEL_NONE;
        sel_inner_d = 4'h0;
        sel_outer_d = 4'h0;
        unique case (SEL_INNER_I)
            `CCM_INNER_1: begin
                sel_kind_d = CCM_SEL_REG;
                sel_inner_d = 4'h1;
                sel_outer_d = SEL_OUTER_I;
            end
            `CCM_INNER_2: begin
                if (SEL_OUTER_I == `CCM_OUTER_MS) begin
                    sel_kind_d = CCM_SEL_MAIN;
                end else if (SEL_OUTER_I == `CCM_OUTER_AS) begin
                    sel_kind_d = CCM_SEL_AUX;
                end
            end
            `CCM_INNER_3: begin
                sel_kind_d = CCM_SEL_REG;
                sel_inner_d = 4'h3;
                sel_outer_d = SEL_OUTER_I;
            end
            default: begin
                sel_kind_d = CCM_SEL_NONE;
            end
        endcase
    end

    // registered selection; panel switches are slow, one cycle costs nothing
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            sel_kind_q <= CCM_SEL_NONE;
            sel_inner_q <= 4'h0;
            sel_outer_q <= 4'h0;
        end else begin
            sel_kind_q <= sel_kind_d;
            sel_inner_q <= sel_inner_d;
            sel_outer_q <= sel_outer_d;
        end
    end

    assign SEL_KIND_O = sel_kind_q;
    assign SEL_REG_INNER_O = sel_inner_q;
    assign SEL_REG_OUTER_O = sel_outer_q;
endmodule : ccm_console_ctrl

// *** verif/ccm_console_chk.sv ***
// port assertions for the console manual-control block
`timescale 1ns/100ps
`include "ccm_cfg.svh"
module ccm_console_chk (
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    input wire logic [`CCM_KEY_COUNT-1:0] KEYS_I,
    input wire logic LAMP_TEST_I,
    input wire logic [`CCM_LAMP_COUNT-1:0] LAMP_FUNC_I,
    input wire logic [15:0] MICRO_ADDR_O,
    input wire logic CPU_CLOCK_RUN_O,
    input wire logic SYS_RESET_O,
    input wire logic MACHINE_RESET_LATCH_O,
    input wire logic DIAG_LATCH_O,
    input wire logic PRIORITY_LATCH_O,
    input wire logic OVERRIDE_LATCH_O,
    input wire logic TRAP_ENABLE_O,
    input wire logic CHECK_RESET_O,
    input wire logic MANUAL_LAMP_O,
    input wire logic [`CCM_LAMP_COUNT-1:0] LAMP_DRIVE_O
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RESET_I);
    property p_rst_addr;
        SYS_RESET_O |-> MICRO_ADDR_O == 16'h0000;
    endproperty
    a_rst_addr: assert property (p_rst_addr)
        else $error("reset address not zero");
    property p_rst_latch;
        SYS_RESET_O |-> MACHINE_RESET_LATCH_O && DIAG_LATCH_O && PRIORITY_LATCH_O
            && !OVERRIDE_LATCH_O;
    endproperty
    a_rst_latch: assert property (p_rst_latch)
        else $error("latches wrong after reset");
    // two sync stages plus the action register
    property p_key_rst;
        $rose(KEYS_I[`CCM_KEY_SYS_RESET]) |-> ##[2:4] SYS_RESET_O;
    endproperty
    a_key_rst: assert property (p_key_rst)
        else $error("reset key gave no reset");
    property p_trap;
        MACHINE_RESET_LATCH_O |-> !TRAP_ENABLE_O;
    endproperty
    a_trap: assert property (p_trap)
        else $error("trap while machine reset set");
    property p_ovr_clr;
        $rose(OVERRIDE_LATCH_O) |-> !CPU_CLOCK_RUN_O ##[0:2] !MACHINE_RESET_LATCH_O
            && !DIAG_LATCH_O;
    endproperty
    a_ovr_clr: assert property (p_ovr_clr)
        else $error("override did not clear latches");
    property p_chk_key;
        $rose(KEYS_I[`CCM_KEY_CHK_RESET]) |-> ##[2:5] CHECK_RESET_O;
    endproperty
    a_chk_key: assert property (p_chk_key)
        else $error("check reset key ignored");
    property p_manual;
        !CPU_CLOCK_RUN_O |-> MANUAL_LAMP_O;
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual lamp off while stopped");
    property p_lamp;
        LAMP_DRIVE_O == (LAMP_FUNC_I | {`CCM_LAMP_COUNT{LAMP_TEST_I}});
    endproperty
    a_lamp: assert property (p_lamp)
        else $error("lamp drive wrong");
    c_rst: cover property (SYS_RESET_O && $past(CPU_CLOCK_RUN_O));
    c_ovr: cover property ($rose(OVERRIDE_LATCH_O));
    c_chk: cover property (CHECK_RESET_O);
endmodule : ccm_console_chk
bind ccm_console_ctrl ccm_console_chk chk_u (.*);

// *** verif/ccm_panel.sv ***
// operator panel model: pushbuttons and rotary switches
`timescale 1ns/100ps
`include "ccm_cfg.svh"
module ccm_panel (
    input wire logic clk_i,
    output logic [`CCM_KEY_COUNT-1:0] keys_o,
    output logic [15:0] data_sw_o,
    output logic [1:0] sel_inner_o,
    output logic [3:0] sel_outer_o,
    output logic ccd_o,
    output logic timer_on_o,
    output logic lamp_test_o
);
    initial begin
        keys_o = '0;
        dial(16'h0000, 2'h0, 4'h0);
        lvl(1'b0, 1'b1, 1'b0);
    end
    // held five cycles: a human press, long past the synchroniser
    task automatic tap(input int k);
        @(negedge clk_i);
        keys_o[k] = 1'b1;
        repeat (5) @(negedge clk_i);
        keys_o[k] = 1'b0;
        repeat (5) @(negedge clk_i);
    endtask : tap
    task automatic dial(input logic [15:0] d, input logic [1:0] inr, input logic [3:0] otr);
        data_sw_o = d;
        sel_inner_o = inr;
        sel_outer_o = otr;
    endtask : dial
    task automatic lvl(input logic ccd, input logic tmr, input logic lt);
        ccd_o = ccd;
        timer_on_o = tmr;
        lamp_test_o = lt;
    endtask : lvl
endmodule : ccm_panel

// *** verif/tb.sv ***
// console manual-control testbench
`timescale 1ns/100ps
`include "ccm_cfg.svh"
module tb;
    import ccm_pkg::*;
    logic CLK_SYS_I, RESET_I, DIAG_PASS_DONE_I, FLAGS_CLEAR_DONE_I, INSTR_END_I, IO_BUSY_I;
    logic INTR_PENDING_I, SHARE_PENDING_I, SHARE_REQ_I, SEL_DATA_REQ_I, TRAP_REQ_I;
    logic CHECK_COMPARE_DISABLE_I, TIMER_SWITCH_ON_I, LAMP_TEST_I;
    logic [`CCM_KEY_COUNT-1:0] KEYS_I;
    logic [15:0] DATA_SW_I, NEXT_MICRO_ADDR_I, MICRO_ADDR_O, INSTR_COUNTER_DATA_O;
    logic [1:0] SEL_INNER_I, SEL_KIND_O;
    logic [3:0] SEL_OUTER_I, SEL_REG_INNER_O, SEL_REG_OUTER_O;
    logic [`CCM_LAMP_COUNT-1:0] LAMP_FUNC_I, LAMP_DRIVE_O;
    logic CPU_CLOCK_RUN_O, SYS_RESET_O, REG_CLEAR_O, MACHINE_RESET_LATCH_O, DIAG_LATCH_O;
    logic PRIORITY_LATCH_O, OVERRIDE_LATCH_O, TRAP_ENABLE_O, DIAG_RUN_O, CLEAR_FLAGS_O;
    logic LOAD_PSW_O, LOAD_INSTR_COUNTER_O, CHECK_RESET_O, MANUAL_LAMP_O, SHARE_SERVE_O;
    logic SEL_CYCLE_SERVE_O, SHOW_NEXT_ADDR_O, TIMER_CTRL_LATCH_O;
    int n_mismatch = 0;
    int comparisons = 0;
    int n_rst = 0, n_clr = 0, n_psw = 0, n_lic = 0, n_chk = 0;
    bit seen_ovr;
    ccm_console_ctrl dut_u (.*);
    ccm_panel pnl_u (.clk_i(CLK_SYS_I), .keys_o(KEYS_I), .data_sw_o(DATA_SW_I),
        .sel_inner_o(SEL_INNER_I), .sel_outer_o(SEL_OUTER_I), .ccd_o(CHECK_COMPARE_DISABLE_I),
        .timer_on_o(TIMER_SWITCH_ON_I), .lamp_test_o(LAMP_TEST_I));
    // one-cycle pulses are counted, so key tasks need not hit the exact edge
    always @(posedge CLK_SYS_I) begin
        n_rst += (SYS_RESET_O === 1'b1);
        n_clr += (REG_CLEAR_O === 1'b1);
        n_psw += (LOAD_PSW_O === 1'b1);
        n_lic += (LOAD_INSTR_COUNTER_O === 1'b1);
        n_chk += (CHECK_RESET_O === 1'b1);
        if (MICRO_ADDR_O === 16'h1234) seen_ovr = 1'b1;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK_SYS_I);
    endtask : cyc
    task automatic sys_reset();
        int r0 = n_rst;
        int c0 = n_clr;
        pnl_u.tap(`CCM_KEY_SYS_RESET);
        chk("rst_pulses", 16'(n_rst - r0), 16'h1);
        chk("clr_pulses", 16'(n_clr - c0), 16'h1);
        chk("addr", MICRO_ADDR_O, 16'h0000);
        chk("run", CPU_CLOCK_RUN_O, 1'b0);
        chk("latches", {MACHINE_RESET_LATCH_O, DIAG_LATCH_O, PRIORITY_LATCH_O}, 3'h7);
        chk("ovr", OVERRIDE_LATCH_O, 1'b0);
        chk("trap", TRAP_ENABLE_O, 1'b0);
    endtask : sys_reset
    task automatic boot(input bit dis);
        int p0 = n_psw;
        pnl_u.lvl(dis, 1'b1, 1'b0);
        pnl_u.tap(`CCM_KEY_START);
        chk("diag_run", DIAG_RUN_O, !dis);
        for (int i = 1; i <= 128 && !dis; i++) begin
            if (i == 128) chk("diag_127", DIAG_RUN_O, 1'b1);
            DIAG_PASS_DONE_I = 1'b1;
            cyc(1);
            DIAG_PASS_DONE_I = 1'b0;
            cyc(1);
        end
        cyc(2);
        chk("diag_end", DIAG_RUN_O, 1'b0);
        chk("flags", {CLEAR_FLAGS_O, MACHINE_RESET_LATCH_O}, 2'h3);
        FLAGS_CLEAR_DONE_I = 1'b1;
        cyc(1);
        FLAGS_CLEAR_DONE_I = 1'b0;
        cyc(3);
        chk("mreset", {MACHINE_RESET_LATCH_O, TRAP_ENABLE_O}, 2'h1);
        pnl_u.tap(`CCM_KEY_START);
        chk("psw", 16'(n_psw - p0), 16'h1);
        chk("run", CPU_CLOCK_RUN_O, 1'b1);
    endtask : boot
    task automatic stop_run();
        {INSTR_END_I, INTR_PENDING_I, IO_BUSY_I} = 3'b011;
        pnl_u.tap(`CCM_KEY_STOP);
        chk("run_instr", CPU_CLOCK_RUN_O, 1'b1);
        INSTR_END_I = 1'b1;
        cyc(4);
        chk("run_intr", CPU_CLOCK_RUN_O, 1'b1);
        INTR_PENDING_I = 1'b0;
        cyc(4);
        chk("run_io", CPU_CLOCK_RUN_O, 1'b1);
        IO_BUSY_I = 1'b0;
        cyc(4);
        chk("stopped", {CPU_CLOCK_RUN_O, MANUAL_LAMP_O}, 2'h1);
        INSTR_END_I = 1'b0;
        {SHARE_REQ_I, SEL_DATA_REQ_I} = 2'h3;
        cyc(1);
        chk("serve", {SHARE_SERVE_O, SEL_CYCLE_SERVE_O, SHOW_NEXT_ADDR_O}, 3'h7);
        {SHARE_REQ_I, SEL_DATA_REQ_I} = 2'h0;
    endtask : stop_run
    task automatic override_run(input bit after_rst);
        pnl_u.dial(16'h1234, 2'h0, 4'h0);
        pnl_u.tap(`CCM_KEY_OVERRIDE);
        chk("ovr_set", {OVERRIDE_LATCH_O, CPU_CLOCK_RUN_O}, 2'h2);
        if (after_rst) chk("ovr_clr", {MACHINE_RESET_LATCH_O, DIAG_LATCH_O}, 2'h0);
        seen_ovr = 1'b0;
        pnl_u.tap(`CCM_KEY_START);
        chk("ovr_load", seen_ovr, 1'b1);
        chk("no_diag", {CPU_CLOCK_RUN_O, DIAG_RUN_O, CLEAR_FLAGS_O}, 3'h4);
        pnl_u.tap(`CCM_KEY_OVERRIDE);
        chk("ovr_refused", OVERRIDE_LATCH_O, 1'b0);
    endtask : override_run
    task automatic set_ic(input bit after_rst);
        int l0 = n_lic;
        pnl_u.dial(16'h0ABC, 2'h0, 4'h0);
        SHARE_PENDING_I = 1'b1;
        pnl_u.tap(`CCM_KEY_SET_IC);
        if (after_rst) begin
            chk("ic_early", {CLEAR_FLAGS_O, 15'(n_lic - l0)}, 16'h8000);
            FLAGS_CLEAR_DONE_I = 1'b1;
            cyc(1);
            FLAGS_CLEAR_DONE_I = 1'b0;
            cyc(3);
        end
        chk("ic_load", 16'(n_lic - l0), 16'h1);
        chk("ic_data", INSTR_COUNTER_DATA_O, 16'h0ABC);
        NEXT_MICRO_ADDR_I = 16'h00FF;
        cyc(4);
        chk("ic_share", CPU_CLOCK_RUN_O, 1'b1);
        SHARE_PENDING_I = 1'b0;
        cyc(4);
        chk("ic_stop", CPU_CLOCK_RUN_O, 1'b0);
        NEXT_MICRO_ADDR_I = 16'h0042;
    endtask : set_ic
    task automatic misc();
        logic [9:0] sel [5] = '{10'h100, 10'h201, 10'h212, 10'h223, 10'h350};
        int k0 = n_chk;
        pnl_u.lvl(1'b0, 1'b0, 1'b0);
        cyc(1);
        chk("lamp", {LAMP_DRIVE_O, TIMER_CTRL_LATCH_O}, 9'h0B5);
        pnl_u.lvl(1'b0, 1'b1, 1'b1);
        cyc(1);
        chk("lamp_test", {LAMP_DRIVE_O, TIMER_CTRL_LATCH_O}, 9'h1FE);
        pnl_u.lvl(1'b0, 1'b1, 1'b0);
        foreach (sel[i]) begin
            pnl_u.dial(16'h0000, sel[i][9:8], sel[i][7:4]);
            cyc(1);
            chk("sel_kind", SEL_KIND_O, sel[i][1:0]);
            chk("sel_reg", {SEL_REG_INNER_O, SEL_REG_OUTER_O}, (sel[i][9:8] == 2'h2) ? 16'h0000
                : {10'h000, sel[i][9:8], sel[i][7:4]});
        end
        pnl_u.tap(`CCM_KEY_CHK_RESET);
        chk("chk_reset", 16'(n_chk - k0), 16'h1);
    endtask : misc
    task automatic resume();
        int p0 = n_psw;
        pnl_u.tap(`CCM_KEY_START);
        chk("resume", {CPU_CLOCK_RUN_O, MACHINE_RESET_LATCH_O, 14'(n_psw - p0)}, 16'h8000);
        chk("resume_addr", MICRO_ADDR_O, 16'h0042);
    endtask : resume
    task automatic load_key();
        int r0 = n_rst;
        pnl_u.lvl(1'b1, 1'b1, 1'b0);
        pnl_u.tap(`CCM_KEY_LOAD);
        chk("load", {CLEAR_FLAGS_O, MACHINE_RESET_LATCH_O, 14'(n_rst - r0)}, 16'hC001);
    endtask : load_key
    task automatic finish_test();
        if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    initial begin
        CLK_SYS_I = 1'b0;
        forever #12.5 CLK_SYS_I = ~CLK_SYS_I;
    end
    initial begin
        repeat (20000) @(posedge CLK_SYS_I);
        n_mismatch++;
        finish_test();
    end
    initial begin
        {RESET_I, DIAG_PASS_DONE_I, FLAGS_CLEAR_DONE_I, INSTR_END_I, IO_BUSY_I} = 5'h10;
        {INTR_PENDING_I, SHARE_PENDING_I, SHARE_REQ_I, SEL_DATA_REQ_I} = 4'h0;
        TRAP_REQ_I = 1'b1;
        LAMP_FUNC_I = 8'h5A;
        NEXT_MICRO_ADDR_I = 16'h0042;
        cyc(8);
        RESET_I = 1'b0;
        cyc(2);
        sys_reset();
        boot(1'b0);
        stop_run();
        resume();
        stop_run();
        override_run(1'b0);
        sys_reset();
        override_run(1'b1);
        stop_run();
        set_ic(1'b0);
        misc();
        sys_reset();
        set_ic(1'b1);
        load_key();
        sys_reset();
        boot(1'b1);
        finish_test();
    end
endmodule : tb
